// File: inc/bis_pkg.sv
// Constants for the I/O window top and secondary bus status registers
package bis_pkg;
   // Configuration byte offsets
   localparam logic [7:0] OFF_IO_WINDOW_TOP = 8'h1D;
   localparam logic [7:0] OFF_SEC_STATUS = 8'h1E;
   localparam logic [7:0] OFF_IO_UPPER_LIMIT = 8'h32;
   // Dword index and byte lanes; all but the upper status lane derived from the offsets
   localparam logic [5:0] DW_WINDOW = OFF_IO_WINDOW_TOP[7:2];
   localparam logic [1:0] LANE_IO_TOP = OFF_IO_WINDOW_TOP[1:0];
   localparam logic [1:0] LANE_STATUS_LO = OFF_SEC_STATUS[1:0];
   localparam logic [1:0] LANE_STATUS_HI = 2'h3;
   // I/O window top field layout
   localparam int IO_TOP_MSB = 7;
   localparam int IO_TOP_LSB = 4;
   localparam logic [3:0] IO_ADDR_WIDTH_CODE = 4'h1;
   localparam logic [7:0] IO_TOP_RESET = 8'h01;
   localparam logic [11:0] IO_LOW_ONES = 12'hFFF;
   // Secondary status bit positions
   localparam int BIT_PARITY_DETECTED = 15;
   localparam int BIT_SYSTEM_ERROR = 14;
   localparam int BIT_MASTER_ABORT = 13;
   localparam int BIT_TARGET_ABORT_RX = 12;
   localparam int BIT_TARGET_ABORT_SIG = 11;
   localparam int BIT_DATA_PARITY = 8;
   // Fixed status fields
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam logic BACK_TO_BACK_CAP = 1'b1;
   localparam logic HIGH_FREQ_CAP = 1'b1;
   localparam logic RESERVED_BIT6 = 1'b0;
   localparam logic [4:0] RESERVED_LOW = 5'h00;
   // Sticky flag vector indices
   localparam int NUM_FLAGS = 6;
   localparam int FL_DATA_PARITY = 0;
   localparam int FL_TARGET_ABORT_SIG = 1;
   localparam int FL_TARGET_ABORT_RX = 2;
   localparam int FL_MASTER_ABORT = 3;
   localparam int FL_SYSTEM_ERROR = 4;
   localparam int FL_PARITY_DETECTED = 5;
endpackage

// File: src/bis_w1c_flags.sv
// Sticky flags, set by events and cleared by writing one
`timescale 1ns/1ps
module bis_w1c_flags #(
   parameter int WIDTH = 6
) (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic clkEn, // Freezes state while low
   input wire logic [WIDTH-1:0] setEv, // Event pulses
   input wire logic [WIDTH-1:0] clrMask, // Clear strobes
   output logic [WIDTH-1:0] flags // Sticky flag state
);
   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;

   initial begin
      if (WIDTH < 1) begin
         $error("bis_w1c_flags: WIDTH must be at least 1");
      end
   end

   // Set wins over a clear in the same cycle
   always_comb begin
      flags_d = (flags_q & ~clrMask) | setEv;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags_q <= '0;
      end else if (clkEn) begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;
endmodule

// File: src/bis_bridge_regs.sv
// I/O window top and secondary bus status configuration registers
//
// Functional notes
// - Limit bits 7:4 are writable and give I/O window top bits 15:12.
// - Window top low twelve address bits are taken as all ones.
// - Window top bits 31:16 come from the upper limit register at 32h.
// - Limit bits 3:0 read fixed 1h, meaning 32-bit I/O addressing.
// - Bit 15 sets on secondary address/attribute or data parity errors.
// - Bit 15 sets whatever the parity response enable says.
// - Bit 14 sets when SERR is seen on the secondary bus.
// - Bit 13 sets when a mastered secondary transaction master-aborts.
// - Bit 12 sets when a target abort is received on secondary bus.
// - Bit 11 sets when the device signals target abort as target.
// - Bits 10:9 read fixed 01b, medium DEVSEL timing.
// - Bit 8 sets as master with parity response on and PERR involved.
// - Bit 7 reads fixed 1b, fast back-to-back capable.
// - Bit 5 reads fixed 1b, secondary bus runs at 66 MHz.
// - Bit 6 and bits 4:0 are reserved and read zero.
`timescale 1ns/1ps
module bis_bridge_regs #(
   parameter int ADDR_W = 32
) (
   input wire logic sys_clk, // Clock, 100 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic clkEn, // Freezes state while low
   // Configuration access, dword addressed
   input wire logic [5:0] cfgDwIndex, // Dword index (byte offset / 4)
   input wire logic [3:0] cfgByteEn, // Byte enables
   input wire logic cfgWrEn, // Write strobe
   input wire logic cfgRdEn, // Read strobe
   input wire logic [31:0] cfgWrData, // Write data
   output logic [31:0] cfgRdData, // Read data, one cycle after strobe
   output logic cfgRdValid, // Read data valid pulse
   // Window inputs from elsewhere in configuration space
   input wire logic [15:0] ioUpperLimit, // Upper limit register contents
   input wire logic parity_response_enable, // Bridge control bit 0
   // Secondary bus events, one-cycle pulses
   input wire logic addrAttrErrAsTarget, // Address/attribute parity error
   input wire logic dataErrWriteTarget, // Data parity error, write target
   input wire logic dataErrReadMaster, // Data parity error, read master
   input wire logic serrObserved, // SERR seen asserted
   input wire logic masterAbortEnd, // Mastered transaction master-aborted
   input wire logic targetAbortRx, // Target abort received
   input wire logic targetAbortSent, // Target abort signalled as target
   input wire logic actingMaster, // Device masters current transaction
   input wire logic perrAssertedOnRead, // Device drives PERR on a read
   input wire logic perrSeenOnWrite, // PERR observed on a write
   // Window compare
   input wire logic [ADDR_W-1:0] ioAddr, // I/O address to test
   output logic [ADDR_W-1:0] ioWindowTop, // Full window top address
   output logic ioAddrAtOrBelowTop, // ioAddr not above window top
   // Flag state
   output logic sec_parity_detected, // Status bit 15
   output logic sec_system_error_seen, // Status bit 14
   output logic sec_master_abort_seen, // Status bit 13
   output logic sec_target_abort_received, // Status bit 12
   output logic sec_target_abort_signalled, // Status bit 11
   output logic master_data_parity_flag // Status bit 8
);
   logic [3:0] io_window_top_bits_q;
   logic [31:0] cfgRdData_q;
   logic cfgRdValid_q;
   logic [ADDR_W-1:0] ioWindowTop_q;
   logic ioAddrAtOrBelowTop_q;
   logic [bis_pkg::NUM_FLAGS-1:0] setEv;
   logic [bis_pkg::NUM_FLAGS-1:0] clrMask;
   logic [bis_pkg::NUM_FLAGS-1:0] flags;
   logic [7:0] ioTopRead;
   logic [15:0] statusRead;
   logic [31:0] topFull;
   logic windowHit;

   initial begin
      if (ADDR_W != 32) begin
         $error("bis_bridge_regs: ADDR_W must be 32");
      end
   end

   // Write strobe for one byte lane of the window dword
   function automatic logic laneWrite(input logic [5:0] dw,
                                      input logic [3:0] be,
                                      input logic wr,
                                      input logic [1:0] lane);
      laneWrite = wr && (dw == bis_pkg::DW_WINDOW) && be[lane];
   endfunction

   assign windowHit = cfgDwIndex == bis_pkg::DW_WINDOW;

   // Writable window top nibble
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         io_window_top_bits_q <=
            bis_pkg::IO_TOP_RESET[bis_pkg::IO_TOP_MSB:bis_pkg::IO_TOP_LSB];
      end else if (clkEn) begin
         if (laneWrite(cfgDwIndex, cfgByteEn, cfgWrEn,
                       bis_pkg::LANE_IO_TOP)) begin
            io_window_top_bits_q <=
               cfgWrData[8+bis_pkg::IO_TOP_MSB:8+bis_pkg::IO_TOP_LSB];
         end
      end
   end

   // Event sources for the sticky flags
   always_comb begin
      setEv = '0;
      setEv[bis_pkg::FL_PARITY_DETECTED] = addrAttrErrAsTarget |
         dataErrWriteTarget | dataErrReadMaster;
      setEv[bis_pkg::FL_SYSTEM_ERROR] = serrObserved;
      setEv[bis_pkg::FL_MASTER_ABORT] = masterAbortEnd;
      setEv[bis_pkg::FL_TARGET_ABORT_RX] = targetAbortRx;
      setEv[bis_pkg::FL_TARGET_ABORT_SIG] = targetAbortSent;
      setEv[bis_pkg::FL_DATA_PARITY] = actingMaster &
         parity_response_enable &
         (perrAssertedOnRead | perrSeenOnWrite);
   end

   // Write-one-to-clear; all flags live in the upper status byte
   always_comb begin
      clrMask = '0;
      if (laneWrite(cfgDwIndex, cfgByteEn, cfgWrEn,
                    bis_pkg::LANE_STATUS_HI)) begin
         clrMask[bis_pkg::FL_PARITY_DETECTED] =
            cfgWrData[16+bis_pkg::BIT_PARITY_DETECTED];
         clrMask[bis_pkg::FL_SYSTEM_ERROR] =
            cfgWrData[16+bis_pkg::BIT_SYSTEM_ERROR];
         clrMask[bis_pkg::FL_MASTER_ABORT] =
            cfgWrData[16+bis_pkg::BIT_MASTER_ABORT];
         clrMask[bis_pkg::FL_TARGET_ABORT_RX] =
            cfgWrData[16+bis_pkg::BIT_TARGET_ABORT_RX];
         clrMask[bis_pkg::FL_TARGET_ABORT_SIG] =
            cfgWrData[16+bis_pkg::BIT_TARGET_ABORT_SIG];
         clrMask[bis_pkg::FL_DATA_PARITY] =
            cfgWrData[16+bis_pkg::BIT_DATA_PARITY];
      end
   end

   bis_w1c_flags #(
      .WIDTH(bis_pkg::NUM_FLAGS)
   ) u_flags (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .setEv(setEv),
      .clrMask(clrMask),
      .flags(flags)
   );

   // Read images of the two registers
   always_comb begin
      ioTopRead = {io_window_top_bits_q, bis_pkg::IO_ADDR_WIDTH_CODE};
      statusRead = '0;
      statusRead[bis_pkg::BIT_PARITY_DETECTED] =
         flags[bis_pkg::FL_PARITY_DETECTED];
      statusRead[bis_pkg::BIT_SYSTEM_ERROR] = flags[bis_pkg::FL_SYSTEM_ERROR];
      statusRead[bis_pkg::BIT_MASTER_ABORT] = flags[bis_pkg::FL_MASTER_ABORT];
      statusRead[bis_pkg::BIT_TARGET_ABORT_RX] =
         flags[bis_pkg::FL_TARGET_ABORT_RX];
      statusRead[bis_pkg::BIT_TARGET_ABORT_SIG] =
         flags[bis_pkg::FL_TARGET_ABORT_SIG];
      statusRead[10:9] = bis_pkg::DEVSEL_MEDIUM;
      statusRead[bis_pkg::BIT_DATA_PARITY] = flags[bis_pkg::FL_DATA_PARITY];
      statusRead[7] = bis_pkg::BACK_TO_BACK_CAP;
      statusRead[6] = bis_pkg::RESERVED_BIT6;
      statusRead[5] = bis_pkg::HIGH_FREQ_CAP;
      statusRead[4:0] = bis_pkg::RESERVED_LOW;
   end

   // Registered read port; other dwords and the base byte read zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfgRdData_q <= '0;
         cfgRdValid_q <= 1'b0;
      end else if (clkEn) begin
         cfgRdValid_q <= cfgRdEn;
         if (cfgRdEn) begin
            cfgRdData_q <= windowHit ? {statusRead, ioTopRead, 8'h00} : '0;
         end
      end
   end

   // Full window top: upper register, writable nibble, low ones
   assign topFull = {ioUpperLimit, io_window_top_bits_q,
                     bis_pkg::IO_LOW_ONES};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ioWindowTop_q <= '0;
         ioAddrAtOrBelowTop_q <= 1'b0;
      end else if (clkEn) begin
         ioWindowTop_q <= topFull;
         ioAddrAtOrBelowTop_q <= ioAddr <= topFull;
      end
   end

   assign cfgRdData = cfgRdData_q;
   assign cfgRdValid = cfgRdValid_q;
   assign ioWindowTop = ioWindowTop_q;
   assign ioAddrAtOrBelowTop = ioAddrAtOrBelowTop_q;
   assign sec_parity_detected = flags[bis_pkg::FL_PARITY_DETECTED];
   assign sec_system_error_seen = flags[bis_pkg::FL_SYSTEM_ERROR];
   assign sec_master_abort_seen = flags[bis_pkg::FL_MASTER_ABORT];
   assign sec_target_abort_received = flags[bis_pkg::FL_TARGET_ABORT_RX];
   assign sec_target_abort_signalled = flags[bis_pkg::FL_TARGET_ABORT_SIG];
   assign master_data_parity_flag = flags[bis_pkg::FL_DATA_PARITY];
endmodule

// File: testbench/bis_bridge_regs_props.sv
// Assertion checker for the window top and secondary status registers
`timescale 1ns/1ps
module bis_bridge_regs_props #(
   parameter int ADDR_W = 32
) (
   input wire logic sys_clk, rst, clkEn, cfgWrEn, cfgRdEn, cfgRdValid, // Ctl
   input wire logic [5:0] cfgDwIndex, // Dword index
   input wire logic [3:0] cfgByteEn, // Byte enables
   input wire logic [31:0] cfgWrData, cfgRdData, // Config data
   input wire logic [15:0] ioUpperLimit, // Upper limit
   input wire logic [ADDR_W-1:0] ioWindowTop, // Window top
   input wire logic parity_response_enable, actingMaster, // Parity qualifiers
   input wire logic perrAssertedOnRead, perrSeenOnWrite, // Parity events
   input wire logic addrAttrErrAsTarget, dataErrWriteTarget, // Events
   input wire logic dataErrReadMaster, serrObserved, masterAbortEnd, // Events
   input wire logic targetAbortRx, targetAbortSent, // Events
   input wire logic sec_parity_detected, sec_system_error_seen, // Flags
   input wire logic sec_master_abort_seen, sec_target_abort_received, // Flags
   input wire logic sec_target_abort_signalled, master_data_parity_flag // Flags
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic rdTaken;
   logic parClr;
   assign rdTaken = clkEn && cfgRdEn;
   assign parClr = clkEn && cfgWrEn && cfgDwIndex == 6'h07 && cfgByteEn[3]
      && cfgWrData[31];
   property p_rd_answer; rdTaken |=> cfgRdValid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_fixed;
      rdTaken && cfgDwIndex == 6'h07 |=> (cfgRdData[26:16] & 11'h6FF) == 11'h2A0
         && cfgRdData[11:8] == 4'h1;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed bits wrong");
   property p_top;
      clkEn |=> ioWindowTop[11:0] == 12'hFFF
         && ioWindowTop[31:16] == $past(ioUpperLimit);
   endproperty
   a_top: assert property (p_top) else $error("window top wrong");
   property p_parity;
      clkEn && (addrAttrErrAsTarget || dataErrWriteTarget || dataErrReadMaster)
         |=> sec_parity_detected;
   endproperty
   a_parity: assert property (p_parity) else $error("parity not set");
   property p_serr; clkEn && serrObserved |=> sec_system_error_seen; endproperty
   a_serr: assert property (p_serr) else $error("serr not set");
   property p_mab; clkEn && masterAbortEnd |=> sec_master_abort_seen; endproperty
   a_mab: assert property (p_mab) else $error("sec_master_abort_seen not set");
   property p_tar; clkEn && targetAbortRx |=> sec_target_abort_received;
   endproperty
   a_tar: assert property (p_tar) else $error("tabort rx not set");
   property p_tas; clkEn && targetAbortSent |=> sec_target_abort_signalled;
   endproperty
   a_tas: assert property (p_tas) else $error("sec_target_abort_signalled not set");
   property p_dpar;
      $rose(master_data_parity_flag) |-> $past(clkEn && actingMaster
         && parity_response_enable && (perrAssertedOnRead || perrSeenOnWrite));
   endproperty
   a_dpar: assert property (p_dpar) else $error("data parity bad set");
   property p_sticky; sec_parity_detected && !parClr |=> sec_parity_detected;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
   property p_freeze;
      !clkEn |=> $stable(ioWindowTop) && $stable(cfgRdData)
         && $stable(cfgRdValid) && $stable(sec_system_error_seen);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen state moved");
   c_freeze: cover property (!clkEn ##1 clkEn);
   c_read: cover property (rdTaken ##1 cfgRdValid);
   c_dpar: cover property ($rose(master_data_parity_flag));
   c_clear: cover property ($fell(sec_system_error_seen));
endmodule
bind bis_bridge_regs bis_bridge_regs_props #(.ADDR_W(ADDR_W)) u_props (.*);

// File: testbench/bis_sec_bus_model.sv
// Behavioural secondary bus event source
`timescale 1ns/1ps
module bis_sec_bus_model (
   input wire logic sys_clk, // Clock
   input wire logic [9:0] evReq, // Requested events
   output logic [9:0] evOut // Event lines, one cycle each
);
   initial evOut = 10'h000;
   always @(negedge sys_clk) begin
      evOut <= evReq;
   end
endmodule

// File: testbench/bis_bridge_regs_bench.sv
// Self-checking bench for the window top and secondary status registers
`timescale 1ns/1ps
module bis_bridge_regs_bench;
   logic sys_clk = 1'h0, rst = 1'h1, cfgWrEn = 1'h0, cfgRdEn = 1'h0;
   logic parEn = 1'h0, clkEn = 1'h1, cfgRdValid, atOrBelow;
   logic [5:0] cfgDwIndex = 6'h07, flags;
   logic [3:0] cfgByteEn = 4'h0;
   logic [31:0] cfgWrData = 32'h0, ioAddr = 32'h0, cfgRdData, ioWindowTop;
   logic [31:0] rdVal;
   logic [15:0] ioUpper = 16'h0;
   logic [9:0] evReq = 10'h0, ev;
   int fails = 0, cmp_count = 0;
   always #5 sys_clk = ~sys_clk;
   bis_sec_bus_model farEnd (.sys_clk(sys_clk), .evReq(evReq), .evOut(ev));
   bis_bridge_regs dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
      .cfgDwIndex(cfgDwIndex), .cfgByteEn(cfgByteEn), .cfgWrEn(cfgWrEn),
      .cfgRdEn(cfgRdEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .ioUpperLimit(ioUpper),
      .parity_response_enable(parEn), .addrAttrErrAsTarget(ev[0]),
      .dataErrWriteTarget(ev[1]), .dataErrReadMaster(ev[2]),
      .serrObserved(ev[3]), .masterAbortEnd(ev[4]), .targetAbortRx(ev[5]),
      .targetAbortSent(ev[6]), .actingMaster(ev[7]),
      .perrAssertedOnRead(ev[8]), .perrSeenOnWrite(ev[9]), .ioAddr(ioAddr),
      .ioWindowTop(ioWindowTop), .ioAddrAtOrBelowTop(atOrBelow),
      .sec_parity_detected(flags[5]), .sec_system_error_seen(flags[4]),
      .sec_master_abort_seen(flags[3]), .sec_target_abort_received(flags[2]),
      .sec_target_abort_signalled(flags[1]),
      .master_data_parity_flag(flags[0]));
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cfg_wr(input logic [3:0] be, input logic [31:0] d);
      @(negedge sys_clk);
      cfgDwIndex = 6'h07;
      cfgByteEn = be;
      cfgWrData = d;
      cfgWrEn = 1'h1;
      @(negedge sys_clk);
      cfgWrEn = 1'h0;
   endtask
   task automatic cfg_rd(input logic [5:0] idx);
      int n;
      @(negedge sys_clk);
      cfgDwIndex = idx;
      cfgRdEn = 1'h1;
      for (n = 0; n < 4 && cfgRdValid !== 1'h1; n++) begin
         @(negedge sys_clk);
         cfgRdEn = 1'h0;
      end
      if (n == 4) begin
         fails++;
         wrap_up();
      end
      rdVal = cfgRdData;
   endtask
   // Request changes on the rising edge; the model shows it one cycle
   task automatic pulse(input logic [9:0] m);
      @(posedge sys_clk);
      evReq = m;
      @(posedge sys_clk);
      evReq = 10'h0;
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic t_window();
      cfg_rd(6'h07);
      chk(rdVal, 32'h02A0_0100);
      cfg_rd(6'h06);
      chk(rdVal, 32'h0);
      ioUpper = 16'h1234;
      cfg_wr(4'h5, 32'hFFFF_FFFF);
      cfg_rd(6'h07);
      chk(rdVal, 32'h02A0_0100);
      cfg_wr(4'h2, 32'h0000_A000);
      cfg_rd(6'h07);
      chk(32'(rdVal[15:8]), 32'hA1);
      chk(ioWindowTop, 32'h1234_AFFF);
      ioAddr = 32'h1234_AFFF;
      repeat (2) @(negedge sys_clk);
      chk(32'(atOrBelow), 32'h1);
      ioAddr = 32'h1234_B000;
      repeat (2) @(negedge sys_clk);
      chk(32'(atOrBelow), 32'h0);
   endtask
   task automatic t_flags();
      int b[7] = '{15, 15, 15, 14, 13, 12, 11};
      logic [31:0] want, flagWant;
      for (int i = 0; i < 7; i++) begin
         want = 32'h02A0 | (32'h1 << b[i]);
         flagWant = 32'h1 << (b[i] - 10);
         pulse(10'(1 << i));
         cfg_rd(6'h07);
         chk(32'(rdVal[31:16]), want);
         chk(32'(flags), flagWant);
         cfg_wr(4'h8, 32'h0);
         cfg_rd(6'h07);
         chk(32'(rdVal[31:16]), want);
         // Ones on read-only bits too: they must not move
         cfg_wr(4'h8, want << 16);
         cfg_rd(6'h07);
         chk(32'(rdVal[31:16]), 32'h02A0);
         chk(32'(flags), 32'h0);
      end
   endtask
   task automatic t_data_parity();
      pulse(10'h180);
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h02A0);
      parEn = 1'h1;
      pulse(10'h300);
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h02A0);
      pulse(10'h280);
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h03A0);
      chk(32'(flags), 32'h01);
      cfg_wr(4'h8, 32'h0100_0000);
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h02A0);
      // Enable on: detected parity sets alongside master data parity
      pulse(10'h184);
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h83A0);
      cfg_wr(4'h8, 32'h8100_0000);
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h02A0);
   endtask
   // Event and clear in one cycle on a flag already set
   task automatic t_set_wins();
      pulse(10'h008);
      @(posedge sys_clk);
      evReq = 10'h008;
      @(negedge sys_clk);
      cfgDwIndex = 6'h07;
      cfgByteEn = 4'h8;
      cfgWrData = 32'h4000_0000;
      cfgWrEn = 1'h1;
      @(posedge sys_clk);
      evReq = 10'h0;
      @(negedge sys_clk);
      cfgWrEn = 1'h0;
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h42A0);
      chk(32'(flags), 32'h10);
      cfg_wr(4'h8, 32'h4000_0000);
      cfg_rd(6'h07);
      chk(32'(rdVal[31:16]), 32'h02A0);
   endtask
   // Nothing moves while the clock enable is low
   task automatic t_freeze();
      @(negedge sys_clk);
      clkEn = 1'h0;
      ioUpper = 16'h00FF;
      cfg_wr(4'h2, 32'h0000_5000);
      pulse(10'h008);
      chk(ioWindowTop, 32'h1234_AFFF);
      chk(32'(flags), 32'h0);
      @(negedge sys_clk);
      clkEn = 1'h1;
      cfg_rd(6'h07);
      chk(rdVal, 32'h02A0_A100);
   endtask
   // Reset in mid-run drops flags and the writable nibble
   task automatic t_reset();
      pulse(10'h010);
      chk(32'(flags), 32'h08);
      @(negedge sys_clk);
      rst = 1'h1;
      repeat (2) @(negedge sys_clk);
      rst = 1'h0;
      chk(32'(flags), 32'h0);
      chk(ioWindowTop, 32'h0);
      cfg_rd(6'h07);
      chk(rdVal, 32'h02A0_0100);
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'h0;
      t_window();
      t_flags();
      t_data_parity();
      t_set_wins();
      t_freeze();
      t_reset();
      wrap_up();
   end
endmodule
